// ---- design/tcd_touch_cal.sv ----
`timescale 1ns/1ps
// What this block does
// R01: point B dot registers, read/write, reset zero
// R02: software keeps off point C dot registers
// R03: point A adc registers, upper nibble zero
// R04: point B adc registers, upper nibble zero
// R05: software keeps off point C adc registers
// R06: x scale register, dots per count times 1000
// R07: x dot from scale, A dot, A adc
// R08: no x calculation while x scale zero
// R09: y scale register, dots per count times 1000
// R10: y dot from scale, A dot, A adc
// R11: no y calculation while y scale zero
// R12: pen on loads adc and dot results
// R13: software uses dots only after calibration
// R14: (adc minus A adc) times scale /1000 plus A dot
module tcd_touch_cal #(
  parameter int ADC_W = 12
) (
  input  wire logic                clock_i,
  input  wire logic                rst_b_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [9:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire tcd_pkg::tcd_touch_t touch_i,
  output logic      [15:0]         x_dot_result_o,
  output logic      [15:0]         y_dot_result_o
);

  // the state layout is fixed by the package
  if (ADC_W != tcd_pkg::ADC_W) begin : g_chk_w
    $error("ADC_W must match the package width");
  end

  tcd_pkg::tcd_state_t state_r;    // registered state
  tcd_pkg::tcd_state_t state_nxt;  // next state
  logic [7:0]          idx;        // register index of request
  logic                req_go;     // new request this cycle
  logic                wr_go;      // new write this cycle
  logic                pen_rise;   // pen went from off to on

  // merge the two low byte lanes into a 16-bit register
  function automatic logic [15:0] lane16(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  sel);
    lane16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  // dot conversion, truncates toward zero; result wraps at 16 bits
  function automatic logic [15:0] dot_calc(input logic [11:0] adc,
                                           input logic [11:0] ref_adc,
                                           input logic [15:0] scale,
                                           input logic [15:0] ref_dot);
    logic signed [12:0] diff;
    logic signed [29:0] prod;
    logic signed [29:0] quo;
    diff = $signed({1'b0, adc}) - $signed({1'b0, ref_adc});
    // widen both operands first so the product is never formed at 17 bits
    prod = 30'(diff) * 30'($signed({1'b0, scale}));
    quo  = prod / tcd_pkg::SCALE_MUL;
    dot_calc = 16'(quo[15:0] + ref_dot);  // R14
  endfunction

  // bus request decode; ack low means a new request
  assign idx      = wb_adr_i[9:2];
  assign req_go   = wb_cyc_i & wb_stb_i & ~state_r.ack;
  assign wr_go    = req_go & wb_we_i;
  assign pen_rise = touch_i.pen & ~state_r.pen;

  // next-state logic: bus slave, capture and conversion
  always_comb begin
    state_nxt     = state_r;
    state_nxt.pen = touch_i.pen;
    // single-cycle registered ack, dropped the cycle after
    state_nxt.ack = req_go;
    if (req_go) begin
      state_nxt.rdat = tcd_pkg::RD_UNMAPPED;
    end
    // read mux; unmapped addresses answer zero
    if (req_go && !wb_we_i) begin
      if (idx == tcd_pkg::IDX_XTOUCH) begin
        state_nxt.rdat = {20'h0_0000, state_r.xtouch};
      end else if (idx == tcd_pkg::IDX_YTOUCH) begin
        state_nxt.rdat = {20'h0_0000, state_r.ytouch};
      end else if (idx == tcd_pkg::IDX_XDOT) begin
        state_nxt.rdat = {16'h0000, state_r.xdot};
      end else if (idx == tcd_pkg::IDX_YDOT) begin
        state_nxt.rdat = {16'h0000, state_r.ydot};
      end else if (idx == tcd_pkg::IDX_A_XDOT) begin
        state_nxt.rdat = {16'h0000, state_r.a_xdot};
      end else if (idx == tcd_pkg::IDX_A_YDOT) begin
        state_nxt.rdat = {16'h0000, state_r.a_ydot};
      end else if (idx == tcd_pkg::IDX_B_XDOT) begin
        state_nxt.rdat = {16'h0000, state_r.b_xdot};  // R01
      end else if (idx == tcd_pkg::IDX_B_YDOT) begin
        state_nxt.rdat = {16'h0000, state_r.b_ydot};  // R01
      end else if (idx == tcd_pkg::IDX_C_XDOT) begin
        state_nxt.rdat = {16'h0000, state_r.c_xdot};
      end else if (idx == tcd_pkg::IDX_C_YDOT) begin
        state_nxt.rdat = {16'h0000, state_r.c_ydot};
      end else if (idx == tcd_pkg::IDX_A_XADC) begin
        state_nxt.rdat = {20'h0_0000, state_r.a_xadc};  // R03
      end else if (idx == tcd_pkg::IDX_A_YADC) begin
        state_nxt.rdat = {20'h0_0000, state_r.a_yadc};  // R03
      end else if (idx == tcd_pkg::IDX_B_XADC) begin
        state_nxt.rdat = {20'h0_0000, state_r.b_xadc};  // R04
      end else if (idx == tcd_pkg::IDX_B_YADC) begin
        state_nxt.rdat = {20'h0_0000, state_r.b_yadc};  // R04
      end else if (idx == tcd_pkg::IDX_C_XADC) begin
        state_nxt.rdat = {20'h0_0000, state_r.c_xadc};
      end else if (idx == tcd_pkg::IDX_C_YADC) begin
        state_nxt.rdat = {20'h0_0000, state_r.c_yadc};
      end else if (idx == tcd_pkg::IDX_XSCALE) begin
        state_nxt.rdat = {16'h0000, state_r.xscale};  // R06
      end else if (idx == tcd_pkg::IDX_YSCALE) begin
        state_nxt.rdat = {16'h0000, state_r.yscale};  // R09
      end
    end
    // writes; result registers are read-only and ignore them
    if (wr_go) begin
      if (idx == tcd_pkg::IDX_A_XDOT) begin
        state_nxt.a_xdot = lane16(state_r.a_xdot, wb_dat_i, wb_sel_i);
      end else if (idx == tcd_pkg::IDX_A_YDOT) begin
        state_nxt.a_ydot = lane16(state_r.a_ydot, wb_dat_i, wb_sel_i);
      end else if (idx == tcd_pkg::IDX_B_XDOT) begin
        state_nxt.b_xdot = lane16(state_r.b_xdot, wb_dat_i, wb_sel_i);  // R01
      end else if (idx == tcd_pkg::IDX_B_YDOT) begin
        state_nxt.b_ydot = lane16(state_r.b_ydot, wb_dat_i, wb_sel_i);  // R01
      end else if (idx == tcd_pkg::IDX_C_XDOT) begin
        // reserved storage, kept only so a stray write is harmless
        state_nxt.c_xdot = lane16(state_r.c_xdot, wb_dat_i, wb_sel_i);
      end else if (idx == tcd_pkg::IDX_C_YDOT) begin
        state_nxt.c_ydot = lane16(state_r.c_ydot, wb_dat_i, wb_sel_i);
      end else if (idx == tcd_pkg::IDX_A_XADC) begin
        // upper nibble is read-only and dropped
        state_nxt.a_xadc = 12'(lane16({4'h0, state_r.a_xadc}, wb_dat_i, wb_sel_i));  // R03
      end else if (idx == tcd_pkg::IDX_A_YADC) begin
        state_nxt.a_yadc = 12'(lane16({4'h0, state_r.a_yadc}, wb_dat_i, wb_sel_i));  // R03
      end else if (idx == tcd_pkg::IDX_B_XADC) begin
        state_nxt.b_xadc = 12'(lane16({4'h0, state_r.b_xadc}, wb_dat_i, wb_sel_i));  // R04
      end else if (idx == tcd_pkg::IDX_B_YADC) begin
        state_nxt.b_yadc = 12'(lane16({4'h0, state_r.b_yadc}, wb_dat_i, wb_sel_i));  // R04
      end else if (idx == tcd_pkg::IDX_C_XADC) begin
        state_nxt.c_xadc = 12'(lane16({4'h0, state_r.c_xadc}, wb_dat_i, wb_sel_i));
      end else if (idx == tcd_pkg::IDX_C_YADC) begin
        state_nxt.c_yadc = 12'(lane16({4'h0, state_r.c_yadc}, wb_dat_i, wb_sel_i));
      end else if (idx == tcd_pkg::IDX_XSCALE) begin
        state_nxt.xscale = lane16(state_r.xscale, wb_dat_i, wb_sel_i);  // R06
      end else if (idx == tcd_pkg::IDX_YSCALE) begin
        state_nxt.yscale = lane16(state_r.yscale, wb_dat_i, wb_sel_i);  // R09
      end
    end
    // sequencer: capture on pen-on, convert the cycle after
    case (state_r.st)
      tcd_pkg::ST_IDLE: begin
        if (pen_rise) begin
          state_nxt.xtouch = touch_i.x;  // R12
          state_nxt.ytouch = touch_i.y;  // R12
          state_nxt.st     = tcd_pkg::ST_CALC;
        end
      end
      tcd_pkg::ST_CALC: begin
        // a zero scale leaves the old dot result in place
        if (state_r.xscale != 16'h0000) begin  // R08
          state_nxt.xdot = dot_calc(state_r.xtouch, state_r.a_xadc,
                                    state_r.xscale, state_r.a_xdot);  // R07
        end
        if (state_r.yscale != 16'h0000) begin  // R11
          state_nxt.ydot = dot_calc(state_r.ytouch, state_r.a_yadc,
                                    state_r.yscale, state_r.a_ydot);  // R10
        end
        state_nxt.st = tcd_pkg::ST_IDLE;
      end
      default: begin
        state_nxt.st = tcd_pkg::ST_IDLE;
      end
    endcase
  end

  // state register; every field resets to zero except st, which loads ST_IDLE
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r    <= '0;
      state_r.st <= tcd_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o       = state_r.rdat;
  assign wb_ack_o       = state_r.ack;
  assign x_dot_result_o = state_r.xdot;
  assign y_dot_result_o = state_r.ydot;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_b_dot_write: assert property ( // R01
    wr_go && idx == tcd_pkg::IDX_B_XDOT && wb_sel_i[1:0] == 2'b11
    |=> state_r.b_xdot == $past(wb_dat_i[15:0]))
    else $error("point B x dot not written");

  chk_a_adc_upper: assert property ( // R03
    req_go && !wb_we_i && idx == tcd_pkg::IDX_A_XADC
    |=> wb_ack_o && wb_dat_o[31:12] == 20'h0_0000)
    else $error("point A adc upper bits not zero");

  chk_b_adc_write: assert property ( // R04
    wr_go && idx == tcd_pkg::IDX_B_YADC && wb_sel_i[1:0] == 2'b11
    |=> state_r.b_yadc == $past(wb_dat_i[11:0]))
    else $error("point B y adc not written");

  chk_x_scale_rw: assert property ( // R06
    wr_go && idx == tcd_pkg::IDX_XSCALE && wb_sel_i[1:0] == 2'b11
    |=> state_r.xscale == $past(wb_dat_i[15:0]))
    else $error("x scale not written");

  chk_x_scale_read: assert property ( // R06
    req_go && !wb_we_i && idx == tcd_pkg::IDX_XSCALE
    |=> wb_ack_o && wb_dat_o == {16'h0000, $past(state_r.xscale)})
    else $error("x scale readback wrong");

  chk_y_scale_rw: assert property ( // R09
    wr_go && idx == tcd_pkg::IDX_YSCALE && wb_sel_i[1:0] == 2'b11
    |=> state_r.yscale == $past(wb_dat_i[15:0]))
    else $error("y scale not written");

  chk_x_dot_calc: assert property ( // R07
    state_r.st == tcd_pkg::ST_CALC && state_r.xscale != 16'h0000
    |=> x_dot_result_o == 16'(($signed({1'b0, $past(state_r.xtouch)})
        - $signed({1'b0, $past(state_r.a_xadc)}))
        * $signed({1'b0, $past(state_r.xscale)}) / 1000
        + $signed({1'b0, $past(state_r.a_xdot)})))
    else $error("x dot result wrong");

  chk_y_dot_calc: assert property ( // R10
    state_r.st == tcd_pkg::ST_CALC && state_r.yscale != 16'h0000
    |=> y_dot_result_o == 16'(($signed({1'b0, $past(state_r.ytouch)})
        - $signed({1'b0, $past(state_r.a_yadc)}))
        * $signed({1'b0, $past(state_r.yscale)}) / 1000
        + $signed({1'b0, $past(state_r.a_ydot)})))
    else $error("y dot result wrong");

  chk_x_zero_skip: assert property ( // R08
    state_r.st == tcd_pkg::ST_CALC && state_r.xscale == 16'h0000
    |=> $stable(x_dot_result_o))
    else $error("x dot changed with zero scale");

  chk_y_zero_skip: assert property ( // R11
    state_r.st == tcd_pkg::ST_CALC && state_r.yscale == 16'h0000
    |=> $stable(y_dot_result_o))
    else $error("y dot changed with zero scale");

  chk_pen_capture: assert property ( // R12
    state_r.st == tcd_pkg::ST_IDLE && pen_rise
    |=> state_r.st == tcd_pkg::ST_CALC && state_r.xtouch == $past(touch_i.x)
        && state_r.ytouch == $past(touch_i.y) ##1 state_r.st == tcd_pkg::ST_IDLE)
    else $error("pen-on capture sequence wrong");

endmodule // tcd_touch_cal

// ---- design/tcd_pkg.sv ----
package tcd_pkg;
  // data widths
  localparam int ADC_W = 12;
  localparam int DOT_W = 16;
  localparam int ADR_W = 10;

  // register indices; byte address is index times four
  localparam logic [7:0] IDX_XTOUCH = 8'h24;  // x touch adc result, ro
  localparam logic [7:0] IDX_YTOUCH = 8'h26;  // y touch adc result, ro
  localparam logic [7:0] IDX_XDOT   = 8'h28;  // x dot result, ro
  localparam logic [7:0] IDX_YDOT   = 8'h2A;  // y dot result, ro
  localparam logic [7:0] IDX_A_XDOT = 8'h2C;
  localparam logic [7:0] IDX_A_YDOT = 8'h2E;
  localparam logic [7:0] IDX_B_XDOT = 8'h30;
  localparam logic [7:0] IDX_B_YDOT = 8'h32;
  localparam logic [7:0] IDX_C_XDOT = 8'h34;
  localparam logic [7:0] IDX_C_YDOT = 8'h36;
  localparam logic [7:0] IDX_A_XADC = 8'h38;
  localparam logic [7:0] IDX_A_YADC = 8'h3A;
  localparam logic [7:0] IDX_B_XADC = 8'h3C;
  localparam logic [7:0] IDX_B_YADC = 8'h3E;
  localparam logic [7:0] IDX_C_XADC = 8'h40;
  localparam logic [7:0] IDX_C_YADC = 8'h42;
  localparam logic [7:0] IDX_XSCALE = 8'h44;
  localparam logic [7:0] IDX_YSCALE = 8'h46;

  // scale registers hold dots per count times this
  localparam logic signed [29:0] SCALE_MUL = 30'sh3E8;
  // read answer for unmapped addresses
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // conversion sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CALC = 2'b10
  } tcd_st_t;

  // sample from the panel a/d path
  typedef struct packed {
    logic        pen;
    logic [11:0] x;
    logic [11:0] y;
  } tcd_touch_t;

  // whole state of the block
  typedef struct packed {
    tcd_st_t     st;
    logic        pen;
    logic        ack;
    logic [31:0] rdat;
    logic [15:0] a_xdot;
    logic [15:0] a_ydot;
    logic [15:0] b_xdot;
    logic [15:0] b_ydot;
    logic [15:0] c_xdot;
    logic [15:0] c_ydot;
    logic [11:0] a_xadc;
    logic [11:0] a_yadc;
    logic [11:0] b_xadc;
    logic [11:0] b_yadc;
    logic [11:0] c_xadc;
    logic [11:0] c_yadc;
    logic [15:0] xscale;
    logic [15:0] yscale;
    logic [11:0] xtouch;
    logic [11:0] ytouch;
    logic [15:0] xdot;
    logic [15:0] ydot;
  } tcd_state_t;
endpackage

// ---- verification/tcd_panel_model.sv ----
`timescale 1ns/1ps
// resistive panel seen through the a/d path; pen level plus x/y results
module tcd_panel_model (
  input  wire logic                clock_i,
  input  wire logic                press_i,  // bench holds the pen down
  input  wire logic [11:0]         x_i,      // position while pressed
  input  wire logic [11:0]         y_i,
  output tcd_pkg::tcd_touch_t      touch_o
);
  // a/d results mean nothing with the pen up, so they churn every cycle
  // instead of holding the last value that a lazy design could latch
  always_ff @(posedge clock_i) begin
    touch_o.pen <= press_i;
    if (press_i) begin
      touch_o.x <= x_i;
      touch_o.y <= y_i;
    end else begin
      touch_o.x <= 12'($urandom);
      touch_o.y <= 12'($urandom);
    end
  end
endmodule // tcd_panel_model

// ---- verification/tb_tcd_touch_cal.sv ----
`timescale 1ns/1ps
module tb_tcd_touch_cal;
  logic                clock_i = 1'b0;
  logic                rst_b_i = 1'b0;
  logic                cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0]          adr = 10'h000;
  logic [3:0]          sel = 4'h0;
  logic [31:0]         dat = 32'h0000_0000;
  logic [31:0]         wb_dat_o;
  logic                wb_ack_o;
  logic                press = 1'b0;
  logic [11:0]         px = 12'h000, py = 12'h000;
  tcd_pkg::tcd_touch_t touch;
  logic [15:0]         xd, yd;
  logic [31:0]         q[$];        // expected read data, oldest first
  int                  n_errors = 0, n_checks = 0;
  logic [7:0]          regs[10];    // dot/scale first, then 4 adc regs
  int                  ax, ay, adx, ady, sx, sy, tx, ty, ex;

  always #20 clock_i = ~clock_i;

  tcd_touch_cal #(.ADC_W(12)) i_dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .touch_i(touch),
    .x_dot_result_o(xd), .y_dot_result_o(yd));

  tcd_panel_model i_panel (
    .clock_i(clock_i), .press_i(press), .x_i(px), .y_i(py), .touch_o(touch));

  // expected dot: signed offset from point a, scaled, truncated, wrapped
  function automatic logic [15:0] dot(input int t, a, s, d);
    return 16'(((t - a) * s) / 1000 + d);
  endfunction

  // one classic cycle; held until ack is seen, released at that edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    dat <= d;
    do @(posedge clock_i); while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, idx, 32'h0000_0000);
  endtask

  // pen down for a few cycles then up, so the next press is a fresh edge
  task automatic tap(input int x, input int y);
    @(posedge clock_i);
    press <= 1'b1; px <= 12'(x); py <= 12'(y);
    repeat (4) @(posedge clock_i);
    press <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask

  // read monitor: oldest note against the data that comes with ack
  always @(posedge clock_i) begin
    if (wb_ack_o === 1'b1 && we === 1'b0) begin
      n_checks++;
      if (wb_dat_o !== q[0]) begin
        n_errors++;
        $display("[ERR] %0t read %h expected %h", $time, wb_dat_o, q[0]);
      end
      // the dot result pins must agree with the same note
      if (adr[9:2] == tcd_pkg::IDX_XDOT) begin
        n_checks++;
        if (xd !== q[0][15:0]) begin
          n_errors++;
          $display("[ERR] %0t x dot pin %h expected %h", $time, xd, q[0][15:0]);
        end
      end
      if (adr[9:2] == tcd_pkg::IDX_YDOT) begin
        n_checks++;
        if (yd !== q[0][15:0]) begin
          n_errors++;
          $display("[ERR] %0t y dot pin %h expected %h", $time, yd, q[0][15:0]);
        end
      end
      void'(q.pop_front());
    end
  end

  task automatic conclude;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // bound on the whole run; a hang counts an error and ends in a failed verdict
  initial begin
    repeat (5000) @(posedge clock_i);
    n_errors++;
    conclude();
  end

  initial begin
    void'($urandom(32'hFF5D));
    regs = '{tcd_pkg::IDX_B_XDOT, tcd_pkg::IDX_B_YDOT, tcd_pkg::IDX_A_XDOT,
             tcd_pkg::IDX_A_YDOT, tcd_pkg::IDX_XSCALE, tcd_pkg::IDX_YSCALE,
             tcd_pkg::IDX_A_XADC, tcd_pkg::IDX_A_YADC, tcd_pkg::IDX_B_XADC,
             tcd_pkg::IDX_B_YADC};
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    // reset values; point c places are left alone
    foreach (regs[i]) rd(regs[i], 32'h0000_0000);
    // both scales zero: touch adc captured, dots not computed
    tap(12'h5A3, 12'h1C7);
    rd(tcd_pkg::IDX_XTOUCH, 32'h0000_05A3);
    rd(tcd_pkg::IDX_YTOUCH, 32'h0000_01C7);
    rd(tcd_pkg::IDX_XDOT, 32'h0000_0000);
    rd(tcd_pkg::IDX_YDOT, 32'h0000_0000);
    // random write and readback; adc upper nibble reads zero
    foreach (regs[i]) begin
      ex = $urandom;
      bus(1'b1, regs[i], 32'(ex));
      rd(regs[i], 32'(ex) & (i >= 6 ? 32'h0000_0FFF : 32'h0000_FFFF));
    end
    // calibration loaded before any dot is used
    ax = $urandom_range(0, 4095); ay = $urandom_range(0, 4095);
    adx = $urandom_range(0, 65535); ady = $urandom_range(0, 65535);
    sx = $urandom_range(1, 65535); sy = $urandom_range(1, 65535);
    tx = $urandom_range(0, 4095); ty = $urandom_range(0, 4095);
    bus(1'b1, tcd_pkg::IDX_A_XADC, 32'(ax));
    bus(1'b1, tcd_pkg::IDX_A_YADC, 32'(ay));
    bus(1'b1, tcd_pkg::IDX_A_XDOT, 32'(adx));
    bus(1'b1, tcd_pkg::IDX_A_YDOT, 32'(ady));
    bus(1'b1, tcd_pkg::IDX_XSCALE, 32'(sx));
    bus(1'b1, tcd_pkg::IDX_YSCALE, 32'(sy));
    tap(tx, ty);
    rd(tcd_pkg::IDX_XTOUCH, 32'(tx));
    rd(tcd_pkg::IDX_XDOT, {16'h0000, dot(tx, ax, sx, adx)});
    rd(tcd_pkg::IDX_YDOT, {16'h0000, dot(ty, ay, sy, ady)});
    // result registers ignore writes
    bus(1'b1, tcd_pkg::IDX_XDOT, 32'h0000_1234);
    rd(tcd_pkg::IDX_XDOT, {16'h0000, dot(tx, ax, sx, adx)});
    // x scale cleared: x keeps old dot, y follows the new touch
    bus(1'b1, tcd_pkg::IDX_XSCALE, 32'h0000_0000);
    tap(4095 - tx, 4095 - ty);
    rd(tcd_pkg::IDX_XDOT, {16'h0000, dot(tx, ax, sx, adx)});
    rd(tcd_pkg::IDX_YDOT, {16'h0000, dot(4095 - ty, ay, sy, ady)});
    repeat (3) @(posedge clock_i);
    conclude();
  end
endmodule // tb_tcd_touch_cal
